// ### design/thuv_defines.vh
`ifndef THUV_DEFINES_VH
`define THUV_DEFINES_VH
// APB register byte offsets
`define REG_CTRL_OFF        8'h00
`define REG_LEVEL_OFF       8'h04
`define REG_DELAY_OFF       8'h08
`define REG_STATUS_OFF      8'h0C
`define REG_IRQ_STAT_OFF    8'h10
`define REG_IRQ_MASK_OFF    8'h14
// Field positions
`define CTRL_ON_BIT         0
`define STAT_START_BIT      0
`define STAT_TRIP_BIT       1
`define STAT_BLOCK_BIT      2
`define STAT_ON_BIT         3
`define IRQ_START_BIT       0
`define IRQ_TRIP_BIT        1
// Settings: reset values and limits
`define OPER_RST            1'b0
`define LEVEL_RST           7'd5
`define LEVEL_MIN           7'd2
`define LEVEL_MAX           7'd10
`define DELAY_RST           12'd30
`define DELAY_MIN           12'd1
`define DELAY_MAX           12'd3600
`define MASK_RST            2'h0
// Timing
`define CLK_FREQ_HZ         200000000
`define MIN_OPERATE_MS      50
`define MIN_OPERATE_CYC     ((`CLK_FREQ_HZ / 1000) * `MIN_OPERATE_MS)
`endif

// ### design/thuv_delay_timer.v
`timescale 1ns/1ps
`include "thuv_defines.vh"
// Definite-time stage: counts seconds while the undervoltage condition holds.
module thuv_delay_timer #(
  parameter integer SEC_CYCLES = `CLK_FREQ_HZ, // Clock cycles per second
  parameter integer MIN_CYCLES = `MIN_OPERATE_CYC // Least operate time in cycles
) (
  input  wire        pclk,      // Clock
  input  wire        presetn,   // Async reset, active low
  input  wire        run,       // Undervoltage condition, qualified
  input  wire [11:0] delay_sec, // Delay setting in seconds
  output reg         started_q, // Started status
  output reg         expired_q  // Delay expired status
);
  reg [31:0] sub_q;
  reg [11:0] sec_q;
  reg [31:0] tot_q;
  wire       sec_tick = (sub_q == SEC_CYCLES - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q     <= 32'h0;
      sec_q     <= 12'h000;
      tot_q     <= 32'h0;
      started_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (!run) begin // [R4] [R10]
      sub_q     <= 32'h0;
      sec_q     <= 12'h000;
      tot_q     <= 32'h0;
      started_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      sub_q     <= sec_tick ? 32'h0 : sub_q + 32'h1;
      if (sec_tick && sec_q != 12'hFFF)
        sec_q <= sec_q + 12'h001; // [R4]
      if (tot_q != 32'hFFFFFFFF)
        tot_q <= tot_q + 32'h1;
      // Both the set delay and the minimum operate time must have passed
      if (sec_q >= delay_sec && tot_q >= MIN_CYCLES - 1)
        expired_q <= 1'b1; // [R2] [R11]
    end
  end
endmodule // thuv_delay_timer

// ### design/third_harmonic_uv_function.v
`timescale 1ns/1ps
`include "thuv_defines.vh"
//Contract
// R1 - Start while third harmonic below level
// R2 - Trip only after full delay elapsed
// R3 - Blocking input disables the function
// R4 - Delay counts only while below level
// R5 - Timing stage feeds separate decision stage
// R6 - Operation off/on, default off
// R7 - Start level 2..10 percent, default 5
// R8 - Delay 1..3600 seconds, default 30
// R9 - Upstream stage supplies third harmonic value
// R10 - Off, block or recovery clears everything; code clears timer, start and trip but not sticky irq status
// R11 - Minimum operate time 50 ms
module third_harmonic_uv_function #(
  parameter integer VW         = 16,              // Measurement width
  parameter [VW-1:0] FULL_SCALE = 16'd10000,      // Value equal to 100 percent
  parameter integer SEC_CYCLES = `CLK_FREQ_HZ,    // Cycles per second
  parameter integer MIN_CYCLES = `MIN_OPERATE_CYC // Least operate time in cycles
) (
  input  wire          pclk,                   // APB clock
  input  wire          presetn,                // Async reset, active low
  input  wire [7:0]    paddr,                  // APB address
  input  wire          psel,                   // APB select
  input  wire          penable,                // APB enable
  input  wire          pwrite,                 // APB direction
  input  wire [31:0]   pwdata,                 // APB write data
  output reg  [31:0]   prdata,                 // APB read data
  output reg           pready,                 // APB ready
  output reg           pslverr,                // APB error
  input  wire [VW-1:0] neutral_third_harmonic, // Third harmonic RMS value
  input  wire          block_in,               // External blocking, active high
  output reg           start_out,              // Start output
  output reg           trip_out,               // Trip output
  output reg           irq                     // Interrupt, active high level
);
  reg          oper_q;
  reg [6:0]    level_q;
  reg [11:0]   delay_q;
  reg [1:0]    irq_stat_q;
  reg [1:0]    irq_mask_q;
  reg          blk_m_q;
  reg          blk_s_q;
  reg          start_d1_q;
  reg          trip_d1_q;
  wire         started;
  wire         expired;
  wire [31:0]  thresh;
  wire         below;
  wire         run;
  wire         start_d;
  wire         trip_d;
  wire         acc;
  wire         wr;
  wire         rd;
  wire         err;
  reg  [31:0]  rdata_d;
  wire [1:0]   irq_set;
  reg  [1:0]   irq_clr;
  wire         hit_ctrl;
  wire         hit_level;
  wire         hit_delay;
  wire         hit_status;
  wire         hit_irq_stat;
  wire         hit_irq_mask;
  wire         we_ctrl;
  wire         we_level;
  wire         we_delay;
  wire         we_irq_stat;
  wire         we_irq_mask;
  wire [1:0]   irq_next;

  // Address match against one register offset
  function reg_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  function [6:0] clamp_level;
    input [31:0] v;
    begin
      if (v[31:0] < {25'h0, `LEVEL_MIN})
        clamp_level = `LEVEL_MIN;
      else if (v[31:0] > {25'h0, `LEVEL_MAX})
        clamp_level = `LEVEL_MAX;
      else
        clamp_level = v[6:0];
    end
  endfunction

  function [11:0] clamp_delay;
    input [31:0] v;
    begin
      if (v[31:0] < {20'h0, `DELAY_MIN})
        clamp_delay = `DELAY_MIN;
      else if (v[31:0] > {20'h0, `DELAY_MAX})
        clamp_delay = `DELAY_MAX;
      else
        clamp_delay = v[11:0];
    end
  endfunction

  // Blocking comes from other logic with no clock relation assumed: synchronise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_m_q <= 1'b0;
      blk_s_q <= 1'b0;
    end else begin
      blk_m_q <= block_in;
      blk_s_q <= blk_m_q;
    end
  end

  // Percent of full scale; 32-bit product leaves plenty of headroom
  assign thresh = ({16'h0, FULL_SCALE} * {25'h0, level_q}) / 32'd100;
  assign below  = ({{(32-VW){1'b0}}, neutral_third_harmonic} < thresh); // [R1] [R9]
  assign run    = oper_q && !blk_s_q && below; // [R3] [R6] [R10]

  thuv_delay_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .MIN_CYCLES (MIN_CYCLES)
  ) u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (run),
    .delay_sec (delay_q),
    .started_q (started),
    .expired_q (expired)
  );

  // Decision stage: the timer lags one cycle, so regate with the live terms
  assign start_d = started && run;                // [R1] [R5] [R10]
  assign trip_d  = expired && run;                // [R2] [R3] [R5]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_out  <= 1'b0;
      trip_out   <= 1'b0;
      start_d1_q <= 1'b0;
      trip_d1_q  <= 1'b0;
    end else begin
      start_out  <= start_d;
      trip_out   <= trip_d;
      start_d1_q <= start_d;
      trip_d1_q  <= trip_d;
    end
  end

  // APB: a request is taken in its first access cycle and answered by a
  // registered pready one cycle later, so every access has one wait state.
  // Read data is loaded when the request is taken, so it stands with pready.
  assign acc = psel && penable && !pready;
  assign rd  = acc && !pwrite;

  // Writes land only on the edge that also samples pready high; a master
  // that aborts before that edge leaves the settings untouched.
  assign wr  = psel && penable && pready && pwrite;

  // Address decode, shared by the error check and the write strobes
  assign hit_ctrl     = reg_hit(paddr, `REG_CTRL_OFF);
  assign hit_level    = reg_hit(paddr, `REG_LEVEL_OFF);
  assign hit_delay    = reg_hit(paddr, `REG_DELAY_OFF);
  assign hit_status   = reg_hit(paddr, `REG_STATUS_OFF);
  assign hit_irq_stat = reg_hit(paddr, `REG_IRQ_STAT_OFF);
  assign hit_irq_mask = reg_hit(paddr, `REG_IRQ_MASK_OFF);

  // Unmapped offsets answer with an error and change nothing
  assign err = !(hit_ctrl || hit_level || hit_delay ||
                 hit_status || hit_irq_stat || hit_irq_mask);

  // Write strobes per register; the status word is read only
  assign we_ctrl     = wr && hit_ctrl;
  assign we_level    = wr && hit_level;
  assign we_delay    = wr && hit_delay;
  assign we_irq_stat = wr && hit_irq_stat;
  assign we_irq_mask = wr && hit_irq_mask;

  // Handshake answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc && err;
    end
  end

  // Read mux; unused upper bits read as zero
  always @* begin
    rdata_d = 32'h0;
    case (paddr)
      `REG_CTRL_OFF: begin
        rdata_d[`CTRL_ON_BIT] = oper_q;
      end
      `REG_LEVEL_OFF: begin
        rdata_d[6:0] = level_q;
      end
      `REG_DELAY_OFF: begin
        rdata_d[11:0] = delay_q;
      end
      `REG_STATUS_OFF: begin
        rdata_d[`STAT_START_BIT] = start_out;
        rdata_d[`STAT_TRIP_BIT]  = trip_out;
        rdata_d[`STAT_BLOCK_BIT] = blk_s_q;
        rdata_d[`STAT_ON_BIT]    = oper_q;
      end
      `REG_IRQ_STAT_OFF: begin
        rdata_d[1:0] = irq_stat_q;
      end
      `REG_IRQ_MASK_OFF: begin
        rdata_d[1:0] = irq_mask_q;
      end
      default: begin
        rdata_d = 32'h0;
      end
    endcase
  end

  // Read data holds until the next read is taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      if (rd)
        prdata <= rdata_d;
    end
  end

  // Operation select; off keeps the whole path idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_q <= `OPER_RST; // [R6]
    end else begin
      if (we_ctrl)
        oper_q <= pwdata[`CTRL_ON_BIT]; // [R6]
    end
  end

  // Start level; out-of-range writes are clamped, never refused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= `LEVEL_RST; // [R7]
    end else begin
      if (we_level)
        level_q <= clamp_level(pwdata); // [R7]
    end
  end

  // Delay setting; changing it mid-count takes effect on the running count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_q <= `DELAY_RST; // [R8]
    end else begin
      if (we_delay)
        delay_q <= clamp_delay(pwdata); // [R8]
    end
  end

  // Interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `MASK_RST;
    end else begin
      if (we_irq_mask)
        irq_mask_q <= pwdata[1:0];
    end
  end

  // Rising edges of start and trip are the interrupt events
  assign irq_set = {trip_d && !trip_d1_q, start_d && !start_d1_q};

  // Write one to clear
  always @* begin
    irq_clr = 2'h0;
    if (we_irq_stat)
      irq_clr = pwdata[1:0];
  end

  // Set wins over a clear in the same cycle, so no event is lost
  assign irq_next = (irq_stat_q & ~irq_clr) | irq_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= irq_next;
    end
  end

  // Level interrupt follows the next status so it rises with the sticky bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_next & irq_mask_q);
    end
  end
endmodule // third_harmonic_uv_function

// ### verification/thuv_checker_assertions.sv
`timescale 1ns/1ps
module thuv_checker (
  input wire        pclk,                   // Clock
  input wire        presetn,                // Reset
  input wire        psel,                   // Select
  input wire        penable,                // Enable
  input wire        pready,                 // Ready
  input wire        pslverr,                // Error
  input wire [15:0] neutral_third_harmonic, // Value
  input wire        block_in,               // Block
  input wire        start_out,              // Start
  input wire        trip_out                // Trip
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence blocked_s; block_in [*5]; endsequence
  sequence high_s; (neutral_third_harmonic >= 16'h03E8) [*3]; endsequence
  block_clear_a: assert property (blocked_s |-> !start_out && !trip_out)
    else $error("start or trip while blocked");
  above_clear_a: assert property (high_s |-> !start_out)
    else $error("start above top level");
  trip_start_a: assert property (trip_out |-> start_out)
    else $error("trip without start");
  trip_early_a: assert property ($rose(trip_out) |-> $past(start_out, 8))
    else $error("trip too soon after start");
  fall_both_a: assert property ($fell(start_out) |-> !trip_out)
    else $error("trip outlived start");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer to access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule // thuv_checker

// ### verification/thuv_source.sv
`timescale 1ns/1ps
// Measurement stage and blocking logic; registered like the real upstream stage
module thuv_source (
  input  wire logic        pclk,                           // Clock
  input  wire logic [15:0] set_val,                        // Wanted value
  input  wire logic        set_blk,                        // Wanted block
  output logic      [15:0] neutral_third_harmonic = 16'hFFFF, // Third harmonic
  output logic             block_in = 1'b0                 // Blocking
);
  always @(posedge pclk) begin
    neutral_third_harmonic <= set_val;
    block_in <= set_blk;
  end
endmodule // thuv_source

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "thuv_defines.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, set_blk = 0, serr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  logic [15:0] set_val = 16'hFFFF, val;
  wire [31:0] prdata;
  wire pready, pslverr, block_in, start_out, trip_out, irq;
  int err_count = 0, total_checks = 0, n;
  logic s_start = 0, s_trip = 0, s_irq = 0;
  initial forever #2.5 pclk = ~pclk;
  // Outputs are looked at half a period after the edge that launches them
  always @(negedge pclk) begin
    s_start <= start_out;
    s_trip <= trip_out;
    s_irq <= irq;
  end
  thuv_source u_thuv_source (.pclk, .set_val, .set_blk, .neutral_third_harmonic(val), .block_in);
  third_harmonic_uv_function #(.SEC_CYCLES(20), .MIN_CYCLES(10)) u_third_harmonic_uv_function (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .neutral_third_harmonic(val), .block_in, .start_out, .trip_out, .irq);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      err_count++;
    rdata = prdata;
    serr = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    end_of_test;
  end
  initial begin
    wait_cyc(12);
    presetn <= 1;
    rd(`REG_CTRL_OFF, 32'h0);
    rd(`REG_LEVEL_OFF, 32'h5);
    rd(`REG_DELAY_OFF, 32'h1E);
    rd(8'h18, 32'h0);
    chk({31'h0, serr}, 32'h1);
    apb(1, `REG_LEVEL_OFF, 32'h1);
    rd(`REG_LEVEL_OFF, 32'h2);
    apb(1, `REG_LEVEL_OFF, 32'hB);
    rd(`REG_LEVEL_OFF, 32'hA);
    apb(1, `REG_DELAY_OFF, 32'h0);
    rd(`REG_DELAY_OFF, 32'h1);
    apb(1, `REG_DELAY_OFF, 32'hFA0);
    rd(`REG_DELAY_OFF, 32'hE10);
    apb(1, `REG_DELAY_OFF, 32'h1);
    apb(1, `REG_LEVEL_OFF, 32'h5);
    set_val <= 16'h0;
    wait_cyc(30);
    chk({31'h0, s_start}, 32'h0);
    apb(1, `REG_IRQ_MASK_OFF, 32'h3);
    apb(1, `REG_CTRL_OFF, 32'h1);
    n = 0;
    while (s_trip !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    // One second is 20 cycles here; a few more for the pipeline and the APB tail
    chk({31'h0, n >= 18 && n <= 26}, 32'h1);
    chk({30'h0, s_irq, s_start}, 32'h3);
    rd(`REG_STATUS_OFF, 32'hB);
    rd(`REG_IRQ_STAT_OFF, 32'h3);
    apb(1, `REG_IRQ_STAT_OFF, 32'h3);
    rd(`REG_IRQ_STAT_OFF, 32'h0);
    chk({31'h0, s_irq}, 32'h0);
    set_val <= 16'h1F4;
    wait_cyc(5);
    chk({30'h0, s_start, s_trip}, 32'h0);
    set_val <= 16'h1F3;
    wait_cyc(12);
    chk({30'h0, s_start, s_trip}, 32'h2);
    chk({31'h0, s_irq}, 32'h1);
    apb(1, `REG_IRQ_MASK_OFF, 32'h0);
    wait_cyc(2);
    chk({31'h0, s_irq}, 32'h0);
    set_blk <= 1;
    wait_cyc(6);
    chk({30'h0, s_start, s_trip}, 32'h0);
    rd(`REG_STATUS_OFF, 32'hC);
    end_of_test;
  end
endmodule // testbench
bind third_harmonic_uv_function thuv_checker u_thuv_checker (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .neutral_third_harmonic, .block_in, .start_out, .trip_out);
